// *** design/sfdph_core.v ***
// discoverable-parameter protocol decode and header map server
// What this block does
// - F5h: class-2 NAND, 3 bytes, 8 waits, fetch
// - FAh: octal DDR, 5 bytes, configurable waits
// - FCh: octal DDR, 3 bytes, half cycle, 8
// - FDh: octal DDR, 4 bytes, 20 waits
// - FEh: octal DDR, 4 bytes, 8 waits
// - FFh: legacy lanes, 3 bytes, 8 waits
// - reserved codes are never reported
// - each header is two 32-bit words
// - first header starts at byte 08h
// - headers follow each other without gaps
// - basic table headers ordered oldest first
// - minor revisions may share start address
// - word one bits 31:24 length, one-based
// - word one bits 23:16 major, minimum 01h
// - word one bits 15:8 minor, from 00h
// - word one bits 7:0 identifier low byte
// - word two: identifier high, start pointer
// - start pointer is word aligned byte address
// - identifier low 00h only with high FFh
`timescale 1ns/1ps
`include "sfdph_consts.vh"
module sfdph_core #(
    parameter HDR_AW = 4,                                        // log2 of header slots
    parameter [15:0] FETCH_CYCLES = `SFDPH_FETCH_US * `SFDPH_CLK_MHZ // class-2 fetch time
) (
    input wire clk_i,             // system clock, 50 MHz
    input wire resetn_i,          // sync reset, active low
    input wire ce_i,              // clock enable, freezes all state when low
    input wire [7:0] proto_code_i, // strapped protocol code, caught after reset
    input wire [4:0] cfg_wait_i,  // wait states for the configurable profile
    input wire hdr_wr_i,          // append one header
    input wire [7:0] hdr_len_i,   // table length in words
    input wire [7:0] hdr_major_i, // major revision
    input wire [7:0] hdr_minor_i, // minor revision
    input wire [15:0] hdr_id_i,   // table identifier, high and low byte
    input wire [23:0] hdr_ptr_i,  // table start byte address
    input wire fetch_i,           // fetch command seen, class-2 only
    input wire rd_req_i,          // parameter-read word request
    input wire [23:0] rd_addr_i,  // byte address of requested word
    output reg [7:0] proto_code_o, // reported protocol code
    output reg code_fault_o,      // strap held a reserved code
    output reg [1:0] lane_mode_o, // lane mode of the read command
    output reg [2:0] addr_bytes_o, // address bytes of the read command
    output reg [4:0] wait_states_o, // wait states of the read command
    output reg half_cycle_o,      // extra half cycle for alignment
    output reg wren_two_o,        // two-byte write-enable opcodes used
    output reg class2_o,          // fetch-then-read behaviour applies
    output reg [7:0] hdr_count_o, // headers held, for the count field
    output reg hdr_reject_o,      // pulse: last append refused
    output reg rd_valid_o,        // pulse: read word valid
    output reg [31:0] rd_data_o,  // read word
    output reg rd_busy_o          // read answered while fetch pending
);
    localparam ST_CAPTURE = 2'h0;
    localparam ST_READY = 2'h1;
    localparam ST_FETCH = 2'h2;
    // slot count caps the map; a full map refuses further appends
    localparam [7:0] SLOTS = 8'h01 << HDR_AW;

    // true for codes that are held back and may not be reported
    function code_reserved;
        input [7:0] code;
        begin
            case (code)
                `SFDPH_CODE_RSV_F6,
                `SFDPH_CODE_RSV_F7,
                `SFDPH_CODE_RSV_F8,
                `SFDPH_CODE_RSV_F9,
                `SFDPH_CODE_RSV_FB: code_reserved = 1'b1;
                default: code_reserved = 1'b0;
            endcase
        end
    endfunction

    reg [1:0] state;
    reg [15:0] fetch_cnt;
    reg [7:0] code_eff;
    reg have_basic;
    reg [15:0] basic_rev;
    reg p1_valid;
    reg p1_hit;
    reg p1_sel;
    reg p1_busy;

    reg [1:0] next_lane;
    reg [2:0] next_abytes;
    reg [4:0] next_wait;
    reg next_half;
    reg next_write_enable_form_two;
    reg next_class2;

    wire params_ready = (state == ST_READY);
    // the count is taken at request time; an append on the same edge shows next time
    wire [23:0] rd_off = rd_addr_i - `SFDPH_FIRST_HDR_OFS;
    wire rd_in_hdrs = (rd_addr_i >= `SFDPH_FIRST_HDR_OFS) &&
        (rd_off[23:3] < {13'h0000, hdr_count_o});
    wire [HDR_AW-1:0] rd_idx = rd_off[HDR_AW+2:3];
    wire is_basic = (hdr_id_i[15:8] == `SFDPH_ID_HI_BASIC) &&
        (hdr_id_i[7:0] == `SFDPH_ID_LO_BASIC);
    wire [15:0] new_rev = {hdr_major_i, hdr_minor_i};
    wire [23:0] ptr_aligned = hdr_ptr_i & `SFDPH_WORD_ALIGN_MASK;

    // a header that would break the map is refused
    wire bad_len = (hdr_len_i < `SFDPH_LEN_MIN);
    wire bad_major = (hdr_major_i < `SFDPH_MAJOR_MIN);
    wire bad_id = (hdr_id_i[7:0] == `SFDPH_ID_LO_BASIC) &&
        (hdr_id_i[15:8] != `SFDPH_ID_HI_BASIC);
    wire bad_order = is_basic && have_basic && (new_rev < basic_rev);
    wire full = (hdr_count_o == SLOTS);
    wire hdr_ok = !bad_len && !bad_major && !bad_id && !bad_order && !full;
    wire hdr_take = ce_i && hdr_wr_i && hdr_ok;

    // word one: length, major, minor and identifier low byte in their fields
    wire [31:0] hdr_word_one;
    assign hdr_word_one[`SFDPH_LEN_MSB:`SFDPH_LEN_LSB] = hdr_len_i;
    assign hdr_word_one[`SFDPH_MAJ_MSB:`SFDPH_MAJ_LSB] = hdr_major_i;
    assign hdr_word_one[`SFDPH_MIN_MSB:`SFDPH_MIN_LSB] = hdr_minor_i;
    assign hdr_word_one[`SFDPH_IDLO_MSB:`SFDPH_IDLO_LSB] = hdr_id_i[7:0];
    // word two: identifier high byte over the aligned start pointer
    wire [31:0] hdr_word_two;
    assign hdr_word_two[`SFDPH_IDHI_MSB:`SFDPH_IDHI_LSB] = hdr_id_i[15:8];
    assign hdr_word_two[`SFDPH_PTR_MSB:`SFDPH_PTR_LSB] = ptr_aligned;
    // two words per entry: word one low half, word two high half
    wire [63:0] hdr_entry = {hdr_word_two, hdr_word_one};

    wire [63:0] mem_q;

    // the write slot is the count itself, so no gap can open between headers
    sfdph_mem #(
        .DW(64),
        .AW(HDR_AW)
    ) u_mem (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .ce_i(ce_i),
        .wr_en_i(hdr_take),
        .wr_addr_i(hdr_count_o[HDR_AW-1:0]),
        .wr_data_i(hdr_entry),
        .rd_en_i(rd_req_i),
        .rd_addr_i(rd_idx),
        .rd_data_o(mem_q)
    );

    // protocol code to read-command shape
    always @* begin
        next_lane = `SFDPH_LANE_SDQ;
        next_abytes = `SFDPH_ABYTES_3;
        next_wait = `SFDPH_WAIT_8;
        next_half = 1'b0;
        next_write_enable_form_two = 1'b0;
        next_class2 = 1'b0;
        case (code_eff)
            `SFDPH_CODE_NAND_C2: begin
                next_class2 = 1'b1;
            end
            `SFDPH_CODE_XNOR_P2: begin
                next_lane = `SFDPH_LANE_OCT_DDR;
                next_abytes = `SFDPH_ABYTES_5;
                next_wait = cfg_wait_i;
                next_write_enable_form_two = 1'b1;
            end
            `SFDPH_CODE_OCT_3B: begin
                next_lane = `SFDPH_LANE_OCT_DDR;
                next_half = 1'b1;
            end
            `SFDPH_CODE_OCT_4B20: begin
                next_lane = `SFDPH_LANE_OCT_DDR;
                next_abytes = `SFDPH_ABYTES_4;
                next_wait = `SFDPH_WAIT_20;
            end
            `SFDPH_CODE_OCT_4B8: begin
                next_lane = `SFDPH_LANE_OCT_DDR;
                next_abytes = `SFDPH_ABYTES_4;
            end
            default: begin
                next_lane = `SFDPH_LANE_SDQ;
            end
        endcase
    end

    // strap capture one edge after reset release, then fetch tracking
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            state <= ST_CAPTURE;
            code_eff <= `SFDPH_CODE_LEGACY;
            code_fault_o <= 1'b0;
            fetch_cnt <= 16'h0000;
        end else if (ce_i) begin
            case (state)
                ST_CAPTURE: begin
                    // a held-back code falls back to legacy behaviour
                    if (code_reserved(proto_code_i)) begin
                        code_eff <= `SFDPH_CODE_LEGACY;
                        code_fault_o <= 1'b1;
                    end else begin
                        code_eff <= proto_code_i;
                    end
                    if (proto_code_i == `SFDPH_CODE_NAND_C2) begin
                        state <= ST_FETCH;
                    end else begin
                        state <= ST_READY;
                    end
                end
                ST_FETCH: begin
                    // tables stay hidden until fetch time has run out
                    if (fetch_cnt != 16'h0000) begin
                        if (fetch_cnt == 16'h0001) begin
                            state <= ST_READY;
                        end
                        fetch_cnt <= fetch_cnt - 16'h0001;
                    end else if (fetch_i) begin
                        fetch_cnt <= FETCH_CYCLES;
                    end
                end
                ST_READY: begin
                    // no way back: the strap is sampled again only after a reset
                    state <= ST_READY;
                end
                default: begin
                    state <= ST_CAPTURE;
                end
            endcase
        end
    end

    // reported shape; the reported code is never a reserved value
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            proto_code_o <= `SFDPH_CODE_LEGACY;
            lane_mode_o <= `SFDPH_LANE_SDQ;
            addr_bytes_o <= `SFDPH_ABYTES_3;
            wait_states_o <= `SFDPH_WAIT_8;
            half_cycle_o <= 1'b0;
            wren_two_o <= 1'b0;
            class2_o <= 1'b0;
        end else if (ce_i) begin
            proto_code_o <= code_eff;
            lane_mode_o <= next_lane;
            addr_bytes_o <= next_abytes;
            wait_states_o <= next_wait;
            half_cycle_o <= next_half;
            wren_two_o <= next_write_enable_form_two;
            class2_o <= next_class2;
        end
    end

    // header append: only at the next free slot, so the map stays contiguous
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            hdr_count_o <= 8'h00;
            hdr_reject_o <= 1'b0;
            have_basic <= 1'b0;
            basic_rev <= 16'h0000;
        end else if (ce_i) begin
            hdr_reject_o <= hdr_wr_i && !hdr_ok;
            if (hdr_take) begin
                hdr_count_o <= hdr_count_o + 8'h01;
                // same start pointer as an older minor revision is allowed
                if (is_basic) begin
                    have_basic <= 1'b1;
                    basic_rev <= new_rev;
                end
            end
        end
    end

    // read stage one: memory lookup, classify the address
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            p1_valid <= 1'b0;
            p1_hit <= 1'b0;
            p1_sel <= 1'b0;
            p1_busy <= 1'b0;
        end else if (ce_i) begin
            p1_valid <= rd_req_i;
            p1_hit <= rd_in_hdrs && params_ready;
            p1_sel <= rd_off[2];
            p1_busy <= !params_ready;
        end
    end

    // read stage two: pick the word; unmapped or hidden words read as zero
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            rd_valid_o <= 1'b0;
            rd_data_o <= 32'h00000000;
            rd_busy_o <= 1'b0;
        end else if (ce_i) begin
            rd_valid_o <= p1_valid;
            if (p1_valid) begin
                rd_busy_o <= p1_busy;
                if (!p1_hit) begin
                    rd_data_o <= 32'h00000000;
                end else if (p1_sel) begin
                    rd_data_o <= mem_q[63:32];
                end else begin
                    rd_data_o <= mem_q[31:0];
                end
            end
        end
    end
endmodule

// *** design/sfdph_consts.vh ***
// constants for the discoverable-parameter header block
`ifndef SFDPH_CONSTS_VH
`define SFDPH_CONSTS_VH

// access-protocol codes
`define SFDPH_CODE_NAND_C2 8'hF5
`define SFDPH_CODE_RSV_F6 8'hF6
`define SFDPH_CODE_RSV_F7 8'hF7
`define SFDPH_CODE_RSV_F8 8'hF8
`define SFDPH_CODE_RSV_F9 8'hF9
`define SFDPH_CODE_XNOR_P2 8'hFA
`define SFDPH_CODE_RSV_FB 8'hFB
`define SFDPH_CODE_OCT_3B 8'hFC
`define SFDPH_CODE_OCT_4B20 8'hFD
`define SFDPH_CODE_OCT_4B8 8'hFE
`define SFDPH_CODE_LEGACY 8'hFF

// lane modes of the parameter-read command
`define SFDPH_LANE_SDQ 2'h0
`define SFDPH_LANE_OCT_DDR 2'h1

// address widths in bytes
`define SFDPH_ABYTES_3 3'h3
`define SFDPH_ABYTES_4 3'h4
`define SFDPH_ABYTES_5 3'h5

// wait-state counts
`define SFDPH_WAIT_8 5'h08
`define SFDPH_WAIT_20 5'h14

// header layout
`define SFDPH_FIRST_HDR_OFS 24'h000008
`define SFDPH_LEN_MSB 31
`define SFDPH_LEN_LSB 24
`define SFDPH_MAJ_MSB 23
`define SFDPH_MAJ_LSB 16
`define SFDPH_MIN_MSB 15
`define SFDPH_MIN_LSB 8
`define SFDPH_IDLO_MSB 7
`define SFDPH_IDLO_LSB 0
`define SFDPH_IDHI_MSB 31
`define SFDPH_IDHI_LSB 24
`define SFDPH_PTR_MSB 23
`define SFDPH_PTR_LSB 0
`define SFDPH_MAJOR_MIN 8'h01
`define SFDPH_ID_LO_BASIC 8'h00
`define SFDPH_ID_HI_BASIC 8'hFF
`define SFDPH_LEN_MIN 8'h01
`define SFDPH_WORD_ALIGN_MASK 24'hFFFFFC

// class-2 fetch time
`define SFDPH_FETCH_US 16'h0078
`define SFDPH_CLK_MHZ 16'h0032

`endif

// *** design/sfdph_mem.v ***
// header storage: one 64-bit entry per parameter header, registered read
`timescale 1ns/1ps
module sfdph_mem #(
    parameter DW = 64,
    parameter AW = 4
) (
    input wire clk_i,              // system clock
    input wire resetn_i,           // sync reset, active low
    input wire ce_i,               // clock enable
    input wire wr_en_i,            // write strobe
    input wire [AW-1:0] wr_addr_i, // write entry index
    input wire [DW-1:0] wr_data_i, // write data
    input wire rd_en_i,            // read strobe
    input wire [AW-1:0] rd_addr_i, // read entry index
    output reg [DW-1:0] rd_data_o  // registered read data
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    // array has no reset; unwritten entries are never exposed by the core
    always @(posedge clk_i) begin
        if (ce_i && wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
    end

    // read data comes from a register
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            rd_data_o <= {DW{1'b0}};
        end else if (ce_i && rd_en_i) begin
            rd_data_o <= mem[rd_addr_i];
        end
    end
endmodule

// *** verification/sfdph_core_checker.sv ***
// assertion checker for the parameter header block
`timescale 1ns/1ps
module sfdph_core_checker (
    input wire clk_i, // clock
    input wire resetn_i, // reset, active low
    input wire ce_i, // clock enable
    input wire hdr_wr_i, // append strobe
    input wire rd_req_i, // read request
    input wire [7:0] hdr_len_i, // table length
    input wire [7:0] hdr_major_i, // major revision
    input wire [15:0] hdr_id_i, // identifier
    input wire [23:0] rd_addr_i, // read address
    input wire [4:0] cfg_wait_i, // configured waits
    input wire [7:0] proto_code_o, // reported code
    input wire code_fault_o, // reserved strap seen
    input wire [1:0] lane_mode_o, // lanes
    input wire [2:0] addr_bytes_o, // address bytes
    input wire [4:0] wait_states_o, // wait states
    input wire half_cycle_o, // half cycle
    input wire wren_two_o, // two-byte write enable
    input wire class2_o, // fetch-then-read
    input wire [7:0] hdr_count_o, // headers held
    input wire hdr_reject_o, // append refused
    input wire rd_valid_o, // answer strobe
    input wire [31:0] rd_data_o, // read word
    input wire rd_busy_o // answer not ready
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // shape judged once the code has settled; shape and code register on the same edge
    property shape(c, l, b, w, f);
        $stable(proto_code_o) && proto_code_o == c |-> lane_mode_o == l
            && addr_bytes_o == b && wait_states_o == w
            && {half_cycle_o, wren_two_o, class2_o} == f;
    endproperty
    // a refused append leaves the count untouched
    property refuse(c);
        ce_i && hdr_wr_i && c |=> hdr_reject_o && $stable(hdr_count_o);
    endproperty
    a_code_nand: assert property (shape(8'hF5, 2'h0, 3'h3, 5'h08, 3'h1))
        else $error("bad shape for F5");
    a_code_prof2: assert property (shape(8'hFA, 2'h1, 3'h5, cfg_wait_i, 3'h2))
        else $error("bad shape for FA");
    a_code_oct3: assert property (shape(8'hFC, 2'h1, 3'h3, 5'h08, 3'h4))
        else $error("bad shape for FC");
    a_code_oct20: assert property (shape(8'hFD, 2'h1, 3'h4, 5'h14, 3'h0))
        else $error("bad shape for FD");
    a_code_oct8: assert property (shape(8'hFE, 2'h1, 3'h4, 5'h08, 3'h0))
        else $error("bad shape for FE");
    a_code_legacy: assert property (shape(8'hFF, 2'h0, 3'h3, 5'h08, 3'h0))
        else $error("bad shape for FF");
    a_no_reserved: assert property (
        !(proto_code_o inside {8'hF6, 8'hF7, 8'hF8, 8'hF9, 8'hFB}))
        else $error("reserved code reported");
    a_read_latency: assert property (ce_i && rd_req_i ##1 ce_i ##1 ce_i |-> rd_valid_o)
        else $error("read answer late");
    a_below_first: assert property (ce_i && rd_req_i && rd_addr_i < 24'h000008
        ##1 ce_i ##1 ce_i |-> rd_data_o == 32'h0) else $error("main header served");
    a_past_count: assert property (ce_i && rd_req_i
        && rd_addr_i >= 24'h000008 + {13'h0, hdr_count_o, 3'h0} ##1 ce_i ##1 ce_i
        |-> rd_data_o == 32'h0) else $error("uncounted header served");
    a_len_zero: assert property (refuse(hdr_len_i == 8'h00))
        else $error("zero length accepted");
    a_major_zero: assert property (refuse(hdr_major_i == 8'h00))
        else $error("zero major accepted");
    a_id_low_basic: assert property (
        refuse(hdr_id_i[7:0] == 8'h00 && hdr_id_i[15:8] != 8'hFF))
        else $error("bad basic id accepted");
    a_fault_legacy: assert property (code_fault_o |-> proto_code_o == 8'hFF)
        else $error("reserved strap not reported as legacy");
    a_ptr_aligned: assert property (ce_i && rd_req_i && rd_addr_i[2] ##1 ce_i ##1 ce_i
        |-> rd_data_o[1:0] == 2'h0) else $error("start pointer not word aligned");
    // a low enable must hold the count and the read word where they stand
    a_ce_freeze: assert property (!ce_i |=> $stable(hdr_count_o) && $stable(rd_data_o))
        else $error("state moved while enable low");
    c_fault: cover property (code_fault_o);
    c_read: cover property (rd_valid_o && !rd_busy_o);
    c_busy: cover property (rd_valid_o && rd_busy_o);
    c_reject: cover property (hdr_reject_o);
endmodule
bind sfdph_core sfdph_core_checker sfdph_core_checker_i (.clk_i(clk_i), .resetn_i(resetn_i),
    .ce_i(ce_i), .hdr_wr_i(hdr_wr_i), .rd_req_i(rd_req_i), .hdr_len_i(hdr_len_i),
    .hdr_major_i(hdr_major_i), .hdr_id_i(hdr_id_i), .rd_addr_i(rd_addr_i),
    .cfg_wait_i(cfg_wait_i), .proto_code_o(proto_code_o), .code_fault_o(code_fault_o),
    .lane_mode_o(lane_mode_o), .addr_bytes_o(addr_bytes_o), .wait_states_o(wait_states_o),
    .half_cycle_o(half_cycle_o), .wren_two_o(wren_two_o), .class2_o(class2_o),
    .hdr_count_o(hdr_count_o), .hdr_reject_o(hdr_reject_o), .rd_valid_o(rd_valid_o),
    .rd_data_o(rd_data_o), .rd_busy_o(rd_busy_o));

// *** verification/sfdph_host.sv ***
// host model that reads header words from the block
`timescale 1ns/1ps
module sfdph_host (
    input wire clk_i, // system clock
    input wire rd_valid_i, // answer strobe
    input wire rd_busy_i, // answer not ready
    input wire [31:0] rd_data_i, // answer word
    output reg rd_req_o, // read request
    output reg [23:0] rd_addr_o // byte address
);
    logic [31:0] got [0:31];
    // idle request at time zero
    initial begin
        rd_req_o = 1'b0;
        rd_addr_o = 24'h000000;
    end
    // one word: request for one cycle, answer awaited a bounded time
    task read(input [23:0] a, output [31:0] d, output b);
        int k;
        d = 'x;
        b = 1'bx;
        @(posedge clk_i);
        #1 rd_req_o = 1'b1;
        rd_addr_o = a;
        @(posedge clk_i);
        #1 rd_req_o = 1'b0;
        rd_addr_o = ~a; // released address shows no stale value
        for (k = 0; k < 4; k++) begin
            @(posedge clk_i);
            #1 if (rd_valid_i === 1'b1) begin
                d = rd_data_i;
                b = rd_busy_i;
                break;
            end
        end
    endtask
    // header walk from 08h, two words per header, stopping at the count
    task walk(input [7:0] n);
        logic b;
        int i;
        for (i = 0; i < 2 * n; i++) read(24'h000008 + 24'(4 * i), got[i], b);
    endtask
endmodule

// *** verification/sfdph_core_tb.sv ***
// testbench for the parameter header block
`timescale 1ns/1ps
module sfdph_core_tb;
    logic clk_i = 1'b0, resetn_i = 1'b0, ce_i = 1'b1, hdr_wr_i = 1'b0, fetch_i = 1'b0;
    logic [7:0] proto_code_i = 8'hFF, hdr_len_i = 8'h00, hdr_major_i = 8'h00;
    logic [7:0] hdr_minor_i = 8'h00, proto_code_o, hdr_count_o;
    logic [4:0] cfg_wait_i = 5'h0B, wait_states_o;
    logic [15:0] hdr_id_i = 16'h0000;
    logic [23:0] hdr_ptr_i = 24'h000000, rd_addr_i;
    logic rd_req_i, rd_valid_o, rd_busy_o, code_fault_o, half_cycle_o, wren_two_o, class2_o;
    logic hdr_reject_o, b;
    logic [1:0] lane_mode_o;
    logic [2:0] addr_bytes_o;
    logic [31:0] rd_data_o, d;
    logic [31:0] ew [$];
    int n_errors = 0, tests_run = 0;
    // 50 MHz clock
    initial forever #10 clk_i = ~clk_i;
    // short fetch time keeps the class-2 wait brief
    sfdph_core #(.HDR_AW(4), .FETCH_CYCLES(16'h0010)) sfdph_core_i (.clk_i(clk_i),
        .resetn_i(resetn_i), .ce_i(ce_i), .proto_code_i(proto_code_i), .cfg_wait_i(cfg_wait_i),
        .hdr_wr_i(hdr_wr_i), .hdr_len_i(hdr_len_i), .hdr_major_i(hdr_major_i),
        .hdr_minor_i(hdr_minor_i), .hdr_id_i(hdr_id_i), .hdr_ptr_i(hdr_ptr_i), .fetch_i(fetch_i),
        .rd_req_i(rd_req_i), .rd_addr_i(rd_addr_i), .proto_code_o(proto_code_o),
        .code_fault_o(code_fault_o), .lane_mode_o(lane_mode_o), .addr_bytes_o(addr_bytes_o),
        .wait_states_o(wait_states_o), .half_cycle_o(half_cycle_o), .wren_two_o(wren_two_o),
        .class2_o(class2_o), .hdr_count_o(hdr_count_o), .hdr_reject_o(hdr_reject_o),
        .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .rd_busy_o(rd_busy_o));
    sfdph_host sfdph_host_i (.clk_i(clk_i), .rd_valid_i(rd_valid_o), .rd_busy_i(rd_busy_o),
        .rd_data_i(rd_data_o), .rd_req_o(rd_req_i), .rd_addr_o(rd_addr_i));
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask
    task results;
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // strap is caught once after release, so each code needs its own reset
    task rst(input [7:0] c);
        @(posedge clk_i);
        #1 resetn_i = 1'b0;
        proto_code_i = c;
        repeat (3) @(posedge clk_i);
        #1 resetn_i = 1'b1;
        repeat (4) @(posedge clk_i);
        #1;
    endtask
    // expected {code, fault, lanes, address bytes, waits, half, wren two, class2}
    function automatic [21:0] shape(input [7:0] c);
        case (c)
            8'hF5: shape = {8'hF5, 1'b0, 2'h0, 3'h3, 5'h08, 3'h1};
            8'hFA: shape = {8'hFA, 1'b0, 2'h1, 3'h5, 5'h0B, 3'h2};
            8'hFC: shape = {8'hFC, 1'b0, 2'h1, 3'h3, 5'h08, 3'h4};
            8'hFD: shape = {8'hFD, 1'b0, 2'h1, 3'h4, 5'h14, 3'h0};
            8'hFE: shape = {8'hFE, 1'b0, 2'h1, 3'h4, 5'h08, 3'h0};
            8'hFF: shape = {8'hFF, 1'b0, 2'h0, 3'h3, 5'h08, 3'h0};
            default: shape = {8'hFF, 1'b1, 2'h0, 3'h3, 5'h08, 3'h0};
        endcase
    endfunction
    // append one header; accepted ones are remembered as their two words
    task app(input [7:0] l, mj, mn, input [15:0] id, input [23:0] p, input rj);
        @(posedge clk_i);
        #1 hdr_wr_i = 1'b1;
        {hdr_len_i, hdr_major_i, hdr_minor_i, hdr_id_i, hdr_ptr_i} = {l, mj, mn, id, p};
        @(posedge clk_i);
        #1 hdr_wr_i = 1'b0;
        // the refusal pulse stands only in the cycle after the strobe
        chk("append refused", {31'h0, rj}, {31'h0, hdr_reject_o});
        if (!rj) begin
            ew.push_back({l, mj, mn, id[7:0]});
            ew.push_back({id[15:8], p & 24'hFFFFFC});
        end
    endtask
    initial begin
        for (int c = 8'hF5; c <= 8'hFF; c++) begin
            rst(8'(c));
            chk("shape", {10'h0, shape(8'(c))},
                {10'h0, proto_code_o, code_fault_o, lane_mode_o, addr_bytes_o,
                wait_states_o, half_cycle_o, wren_two_o, class2_o});
        end
        app(8'h09, 8'h01, 8'h00, 16'hFF00, 24'h000100, 1'b0);
        app(8'h10, 8'h01, 8'h06, 16'hFF00, 24'h000203, 1'b0);
        app(8'h14, 8'h01, 8'h07, 16'hFF00, 24'h000200, 1'b0);
        app(8'h02, 8'h01, 8'h00, 16'hFF84, 24'h000300, 1'b0);
        app(8'h0C, 8'h01, 8'h05, 16'hFF00, 24'h000400, 1'b1);
        app(8'h00, 8'h01, 8'h00, 16'hFF84, 24'h000400, 1'b1);
        app(8'h04, 8'h00, 8'h00, 16'hFF84, 24'h000400, 1'b1);
        app(8'h04, 8'h01, 8'h00, 16'h0100, 24'h000400, 1'b1);
        chk("header count", 32'h4, {24'h0, hdr_count_o});
        sfdph_host_i.walk(hdr_count_o);
        foreach (ew[i]) chk("header word", ew[i], sfdph_host_i.got[i]);
        sfdph_host_i.read(24'h000000, d, b);
        chk("main header word", 32'h0, d);
        sfdph_host_i.read(24'h000028, d, b);
        chk("past last header", 32'h0, d);
        // an append offered while the enable is low must be swallowed
        @(posedge clk_i);
        #1 ce_i = 1'b0;
        hdr_wr_i = 1'b1;
        {hdr_len_i, hdr_major_i, hdr_id_i} = {8'h02, 8'h01, 16'hFF84};
        @(posedge clk_i);
        #1 hdr_wr_i = 1'b0;
        ce_i = 1'b1;
        chk("frozen count", 32'h4, {24'h0, hdr_count_o});
        // class-2 part answers busy until the fetch time has run out
        rst(8'hF5);
        sfdph_host_i.read(24'h000008, d, b);
        chk("busy before fetch", 32'h1, {31'h0, b});
        @(posedge clk_i);
        #1 fetch_i = 1'b1;
        @(posedge clk_i);
        #1 fetch_i = 1'b0;
        sfdph_host_i.read(24'h000008, d, b);
        chk("busy during fetch", 32'h1, {31'h0, b});
        repeat (20) @(posedge clk_i);
        sfdph_host_i.read(24'h000008, d, b);
        chk("ready after fetch", 32'h0, {31'h0, b});
        results;
    end
    // the run needs well under a thousand cycles
    initial begin
        #100000;
        n_errors++;
        results;
    end
endmodule
